// ---- lbc_pkg.sv ----
package lbc_pkg;
    // register offsets on the serial register bus
    localparam logic [7:0] OFS_BANK_ENABLE = 8'h27;
    localparam logic [7:0] OFS_PATTERN_ENABLE_SCALING = 8'h28;
    localparam logic [7:0] OFS_ZONE_SCALE_HIGH = 8'h29;
    localparam logic [7:0] OFS_ZONE_SCALE_MID = 8'h2A;
    localparam logic [7:0] OFS_ZONE_SCALE_LOW = 8'h2B;
    localparam logic [7:0] OFS_BOOST_POLARITY_SELECT = 8'h2C;
    localparam logic [7:0] OFS_SENSOR_GAIN_SELECT = 8'h30;
    localparam logic [7:0] OFS_SENSOR_CONFIG = 8'h31;

    // reset values
    localparam logic [7:0] RST_BANK_ENABLE = 8'h00;
    localparam logic [7:0] RST_PATTERN_ENABLE_SCALING = 8'h00;
    localparam logic [7:0] RST_ZONE_SCALE_HIGH = 8'hFF;
    localparam logic [7:0] RST_ZONE_SCALE_MID = 8'hFF;
    localparam logic [7:0] RST_ZONE_SCALE_LOW = 8'h00;
    localparam logic [7:0] RST_BOOST_POLARITY_SELECT = 8'h08;
    localparam logic [7:0] RST_SENSOR_GAIN_SELECT = 8'h00;
    localparam logic [7:0] RST_SENSOR_CONFIG = 8'h20;

    // implemented bits per register
    localparam logic [7:0] MSK_BANK_ENABLE = 8'h3F;
    localparam logic [7:0] MSK_PATTERN_ENABLE_SCALING = 8'hFF;
    localparam logic [7:0] MSK_ZONE_SCALE_HIGH = 8'hFF;
    localparam logic [7:0] MSK_ZONE_SCALE_MID = 8'hFF;
    localparam logic [7:0] MSK_ZONE_SCALE_LOW = 8'h0F;
    localparam logic [7:0] MSK_BOOST_POLARITY_SELECT = 8'h0F;
    localparam logic [7:0] MSK_SENSOR_GAIN_SELECT = 8'h7F;
    localparam logic [7:0] MSK_SENSOR_CONFIG = 8'h3F;

    localparam int NUM_REGS = 8;
    localparam logic [NUM_REGS-1:0][7:0] REG_OFS = {
        OFS_SENSOR_CONFIG, OFS_SENSOR_GAIN_SELECT, OFS_BOOST_POLARITY_SELECT, OFS_ZONE_SCALE_LOW,
        OFS_ZONE_SCALE_MID, OFS_ZONE_SCALE_HIGH, OFS_PATTERN_ENABLE_SCALING, OFS_BANK_ENABLE};
    localparam logic [NUM_REGS-1:0][7:0] REG_RST = {
        RST_SENSOR_CONFIG, RST_SENSOR_GAIN_SELECT, RST_BOOST_POLARITY_SELECT, RST_ZONE_SCALE_LOW,
        RST_ZONE_SCALE_MID, RST_ZONE_SCALE_HIGH, RST_PATTERN_ENABLE_SCALING, RST_BANK_ENABLE};
    localparam logic [NUM_REGS-1:0][7:0] REG_MSK = {
        MSK_SENSOR_CONFIG, MSK_SENSOR_GAIN_SELECT, MSK_BOOST_POLARITY_SELECT, MSK_ZONE_SCALE_LOW,
        MSK_ZONE_SCALE_MID, MSK_ZONE_SCALE_HIGH, MSK_PATTERN_ENABLE_SCALING, MSK_BANK_ENABLE};
    localparam int IDX_BANK = 0;
    localparam int IDX_PAT = 1;
    localparam int IDX_ZS_HIGH = 2;
    localparam int IDX_ZS_MID = 3;
    localparam int IDX_ZS_LOW = 4;
    localparam int IDX_BOOST = 5;
    localparam int IDX_GAIN = 6;
    localparam int IDX_SENS = 7;

    // field positions
    localparam int POS_PWM_POL = 3;
    localparam int POS_OVP_LO = 1;
    localparam int POS_BOOST_FREQ = 0;
    localparam int POS_AVG_LO = 3;
    localparam int POS_FAST_OFF = 2;
    localparam int POS_INPUT_MODE = 1;
    localparam int POS_SENSOR_EN = 0;
    localparam logic [1:0] CTRL_MAPPER_TWO = 2'h2;
    localparam logic [1:0] CTRL_MAPPER_THREE = 2'h3;

    // timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BOOST_SLOW_HZ = 500_000;
    localparam int unsigned BOOST_FAST_HZ = 1_000_000;
    localparam logic [4:0] BOOST_SLOW_DIV = 5'(CLK_HZ / BOOST_SLOW_HZ);
    localparam logic [4:0] BOOST_FAST_DIV = 5'(CLK_HZ / BOOST_FAST_HZ);
    localparam int unsigned AVG_BASE_US = 17920;
    localparam int unsigned AVG_BASE_CYCLES = AVG_BASE_US * (CLK_HZ / 1_000_000);

    // bus address, arbitrary value
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h36;

    typedef enum {S_IDLE, S_ADDR, S_PTR, S_WR, S_ACK, S_RD, S_RACK} lbc_bus_state_t;
endpackage : lbc_pkg

// ---- lbc_cfg_reg.sv ----
`timescale 1ns/1ns
module lbc_cfg_reg #(
    parameter logic [7:0] RESET = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] q
);
    logic [7:0] q_reg;
    logic [7:0] q_next;

    always_comb begin
        q_next = q_reg;
        if (we) begin
            q_next = wdata & MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= RESET & MASK;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule : lbc_cfg_reg

// ---- lbc_pattern_scaler.sv ----
`timescale 1ns/1ns
module lbc_pattern_scaler (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scale_en,
    input wire logic [3:0] scale_code,
    input wire logic [7:0] level,
    output logic [7:0] scaled
);
    logic [7:0] scaled_reg;
    logic [7:0] scaled_next;
    logic [12:0] product;

    always_comb begin
        product = 13'(level) * 13'({1'b0, scale_code} + 5'h01);
        // code n gives (n+1)/16 of the pattern level
        scaled_next = scale_en ? product[11:4] : level;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scaled_reg <= 8'h00;
        end else begin
            scaled_reg <= scaled_next;
        end
    end

    assign scaled = scaled_reg;
endmodule : lbc_pattern_scaler

// ---- lbc_top.sv ----
`timescale 1ns/1ns
// Functional notes
// - six bank enables, bits 0-5, reset off
// - pattern run enables at even bits, reset off
// - pattern zone scaling at odd bits, reset off
// - enabled pattern overrides mapper two/three targets
// - scale code n gives (n+1)/16
// - zones 4/3 and 2/1 in two registers
// - zone 0 low nibble, resets 1/16
// - pwm polarity bit 3, reset active high
// - overvoltage bits 2:1, frequency bit 0
// - seven-bit gain code, zero is high impedance
// - gain code steps 10 uA per code
// - averaging period 17.92 ms times two^code
// - bit 2 zero enables fast startup
// - bit 1 input mode, bit 0 enable
// - control 10 mapper two, 11 mapper three
module lbc_top #(
    parameter logic [6:0] DEV_ADDR = lbc_pkg::DEV_ADDR_DEFAULT,
    parameter int unsigned AVG_BASE_CYC = lbc_pkg::AVG_BASE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic pwm_in,
    input wire logic [3:0][1:0] lv_current_ctrl,
    input wire logic [3:0] lv_pattern_en,
    input wire logic [3:0][7:0] pattern_level,
    input wire logic [2:0] active_zone,
    output logic [5:0] bank_en,
    output logic [3:0] pattern_run,
    output logic [3:0][7:0] pattern_level_scaled,
    output logic [3:0] lv_use_mapper_two,
    output logic [3:0] lv_use_mapper_three,
    output logic pwm_active,
    output logic [1:0] overvoltage_threshold,
    output logic boost_sw_tick,
    output logic [6:0] sensor_gain_resistor,
    output logic sensor_input_hiz,
    output logic sensor_fast_startup,
    output logic sensor_pwm_mode,
    output logic sensor_enable,
    output logic sensor_avg_tick
);
    import lbc_pkg::*;

    logic [NUM_REGS-1:0][7:0] regs;
    logic [NUM_REGS-1:0] reg_we;
    logic [7:0] rdata;

    // serial bus slave state
    lbc_bus_state_t st_reg, st_next;
    lbc_bus_state_t ack_to_reg, ack_to_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] ptr_reg, ptr_next;
    logic mack_reg, mack_next;
    logic oe_reg, oe_next;
    logic scl_q_reg, sda_q_reg;
    logic sda_out_reg;
    logic wr_stb;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    // steering state
    logic [4:0] div_reg, div_next;
    logic tick_reg, tick_next;
    logic [31:0] avg_reg, avg_next;
    logic avg_tick_reg, avg_tick_next;
    logic [31:0] avg_period;
    logic [3:0] m2_reg, m2_next;
    logic [3:0] m3_reg, m3_next;
    logic pwm_reg, pwm_next;
    logic hiz_reg, hiz_next;
    logic fast_reg, fast_next;
    logic [3:0] zone_code;

    assign scl_rise = scl_in & ~scl_q_reg;
    assign scl_fall = ~scl_in & scl_q_reg;
    assign bus_start = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    assign bus_stop = scl_in & scl_q_reg & ~sda_q_reg & sda_in;

    // register bank: one cell per mapped offset, unused bits masked off
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            assign reg_we[gi] = wr_stb && (ptr_reg == REG_OFS[gi]);
            lbc_cfg_reg #(
                .RESET(REG_RST[gi]),
                .MASK(REG_MSK[gi])
            ) u_reg (
                .mclk(mclk),
                .rst_n(rst_n),
                .we(reg_we[gi]),
                .wdata(sh_reg),
                .q(regs[gi])
            );
        end
    endgenerate

    // unmapped offsets read zero
    always_comb begin
        rdata = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (ptr_reg == REG_OFS[i]) begin
                rdata = regs[i];
            end
        end
    end

    // open-drain slave: oe high pulls the line low
    always_comb begin
        st_next = st_reg;
        ack_to_next = ack_to_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        mack_next = mack_reg;
        oe_next = oe_reg;
        wr_stb = 1'b0;
        if (bus_start) begin
            st_next = S_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (bus_stop) begin
            st_next = S_IDLE;
            oe_next = 1'b0;
        end else begin
            case (st_reg)
                S_ADDR, S_PTR, S_WR: begin
                    if (scl_rise && cnt_reg < 4'h8) begin
                        sh_next = {sh_reg[6:0], sda_in};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == 4'h8) begin
                        cnt_next = 4'h0;
                        oe_next = 1'b1;
                        st_next = S_ACK;
                        case (st_reg)
                            S_ADDR: begin
                                if (sh_reg[7:1] == DEV_ADDR) begin
                                    ack_to_next = sh_reg[0] ? S_RD : S_PTR;
                                end else begin
                                    // another slave addressed: stay off the line
                                    oe_next = 1'b0;
                                    st_next = S_IDLE;
                                end
                            end
                            S_PTR: begin
                                ptr_next = sh_reg;
                                ack_to_next = S_WR;
                            end
                            default: begin
                                wr_stb = 1'b1;
                                ptr_next = ptr_reg + 8'h01;
                                ack_to_next = S_WR;
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        st_next = ack_to_reg;
                        oe_next = 1'b0;
                        if (ack_to_reg == S_RD) begin
                            sh_next = rdata;
                            oe_next = ~rdata[7];
                            ptr_next = ptr_reg + 8'h01;
                            cnt_next = 4'h1;
                        end
                    end
                end
                S_RD: begin
                    if (scl_fall) begin
                        if (cnt_reg == 4'h8) begin
                            oe_next = 1'b0;
                            st_next = S_RACK;
                        end else begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_next = ~sh_reg[6];
                            cnt_next = cnt_reg + 4'h1;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        mack_next = ~sda_in;
                    end else if (scl_fall) begin
                        if (mack_reg) begin
                            sh_next = rdata;
                            oe_next = ~rdata[7];
                            ptr_next = ptr_reg + 8'h01;
                            cnt_next = 4'h1;
                            st_next = S_RD;
                        end else begin
                            st_next = S_IDLE;
                        end
                    end
                end
                default: begin
                    st_next = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= S_IDLE;
            ack_to_reg <= S_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            ptr_reg <= 8'h00;
            mack_reg <= 1'b0;
            oe_reg <= 1'b0;
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            sda_out_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            ack_to_reg <= ack_to_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            ptr_reg <= ptr_next;
            mack_reg <= mack_next;
            oe_reg <= oe_next;
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
            sda_out_reg <= 1'b0;
        end
    end

    // zone scale code for the zone the sensor reports; 1xx is zone 4
    always_comb begin
        case (active_zone)
            3'h0: zone_code = regs[IDX_ZS_LOW][3:0];
            3'h1: zone_code = regs[IDX_ZS_MID][3:0];
            3'h2: zone_code = regs[IDX_ZS_MID][7:4];
            3'h3: zone_code = regs[IDX_ZS_HIGH][3:0];
            default: zone_code = regs[IDX_ZS_HIGH][7:4];
        endcase
    end

    generate
        for (gi = 0; gi < 4; gi++) begin : g_scale
            lbc_pattern_scaler u_scale (
                .mclk(mclk),
                .rst_n(rst_n),
                .scale_en(regs[IDX_PAT][2*gi+1]),
                .scale_code(zone_code),
                .level(pattern_level[gi]),
                .scaled(pattern_level_scaled[gi])
            );
            assign pattern_run[gi] = regs[IDX_PAT][2*gi];
        end
    endgenerate

    always_comb begin
        avg_period = AVG_BASE_CYC << regs[IDX_SENS][POS_AVG_LO +: 3];
        div_next = div_reg + 5'h01;
        tick_next = 1'b0;
        // frequency change applies to the running count; a count at or past the new limit wraps at once
        if (div_reg >= (regs[IDX_BOOST][POS_BOOST_FREQ] ? BOOST_FAST_DIV : BOOST_SLOW_DIV) - 5'h01) begin
            div_next = 5'h00;
            tick_next = 1'b1;
        end
        avg_next = avg_reg + 32'h1;
        avg_tick_next = 1'b0;
        if (!regs[IDX_SENS][POS_SENSOR_EN]) begin
            avg_next = 32'h0;
        end else if (avg_reg >= avg_period - 32'h1) begin
            avg_next = 32'h0;
            avg_tick_next = 1'b1;
        end
        for (int i = 0; i < 4; i++) begin
            // a running pattern wins so it cannot fight the mapper target
            m2_next[i] = (lv_current_ctrl[i] == CTRL_MAPPER_TWO) && !lv_pattern_en[i];
            m3_next[i] = (lv_current_ctrl[i] == CTRL_MAPPER_THREE) && !lv_pattern_en[i];
        end
        pwm_next = regs[IDX_BOOST][POS_PWM_POL] ? pwm_in : ~pwm_in;
        // resistance is 2 V over 10 uA times code, analog side decodes it
        hiz_next = (regs[IDX_GAIN][6:0] == 7'h00);
        fast_next = ~regs[IDX_SENS][POS_FAST_OFF];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 5'h00;
            tick_reg <= 1'b0;
            avg_reg <= 32'h0;
            avg_tick_reg <= 1'b0;
            m2_reg <= 4'h0;
            m3_reg <= 4'h0;
            pwm_reg <= 1'b0;
            hiz_reg <= 1'b1;
            fast_reg <= 1'b1;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
            avg_reg <= avg_next;
            avg_tick_reg <= avg_tick_next;
            m2_reg <= m2_next;
            m3_reg <= m3_next;
            pwm_reg <= pwm_next;
            hiz_reg <= hiz_next;
            fast_reg <= fast_next;
        end
    end

    assign sda_out = sda_out_reg;
    assign sda_oe = oe_reg;
    assign bank_en = regs[IDX_BANK][5:0];
    assign lv_use_mapper_two = m2_reg;
    assign lv_use_mapper_three = m3_reg;
    assign pwm_active = pwm_reg;
    assign overvoltage_threshold = regs[IDX_BOOST][POS_OVP_LO +: 2];
    assign boost_sw_tick = tick_reg;
    assign sensor_gain_resistor = regs[IDX_GAIN][6:0];
    assign sensor_input_hiz = hiz_reg;
    assign sensor_fast_startup = fast_reg;
    assign sensor_pwm_mode = regs[IDX_SENS][POS_INPUT_MODE];
    assign sensor_enable = regs[IDX_SENS][POS_SENSOR_EN];
    assign sensor_avg_tick = avg_tick_reg;
endmodule : lbc_top

// ---- lbc_checker.sv ----
`timescale 1ns/1ns
module lbc_checker #(
    parameter int unsigned AVG_BASE_CYC = 8
) (
    input logic mclk,
    input logic rst_n,
    input logic pwm_in,
    input logic [3:0][1:0] lv_current_ctrl,
    input logic [3:0] lv_pattern_en,
    input logic [3:0][7:0] pattern_level,
    input logic [5:0] bank_en,
    input logic [3:0] pattern_run,
    input logic [3:0][7:0] pattern_level_scaled,
    input logic [3:0] lv_use_mapper_two,
    input logic [3:0] lv_use_mapper_three,
    input logic pwm_active,
    input logic [1:0] overvoltage_threshold,
    input logic boost_sw_tick,
    input logic [6:0] sensor_gain_resistor,
    input logic sensor_input_hiz,
    input logic sensor_enable,
    input logic sensor_avg_tick
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic [3:0] m2_exp, m3_exp, le_ok;
    logic [3:0][7:0] lvl_reg;
    logic [31:0] gap_reg;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            m2_exp[i] = lv_current_ctrl[i] == 2'h2 && !lv_pattern_en[i];
            m3_exp[i] = lv_current_ctrl[i] == 2'h3 && !lv_pattern_en[i];
            le_ok[i] = pattern_level_scaled[i] <= lvl_reg[i];
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_reg <= '0;
            gap_reg <= 32'h0;
        end else begin
            lvl_reg <= pattern_level;
            gap_reg <= sensor_avg_tick ? 32'h0 : gap_reg + 32'h1;
        end
    end
    // nine quiet cycles catch a short divider
    sequence s_boost_quiet;
        !boost_sw_tick [*8] ##1 !boost_sw_tick;
    endsequence
    a_reset_state_clear: assert property (
        !$past(rst_n) |-> bank_en == 6'h00 && pattern_run == 4'h0 && overvoltage_threshold == 2'h0
        && !sensor_enable) else $error("state after reset wrong");
    a_mapper_two_sel: assert property ($past(rst_n) |-> lv_use_mapper_two == $past(m2_exp))
        else $error("mapper two select wrong");
    a_mapper_three_sel: assert property ($past(rst_n) |-> lv_use_mapper_three == $past(m3_exp))
        else $error("mapper three select wrong");
    a_scale_not_above: assert property ($past(rst_n) |-> &le_ok)
        else $error("scaled above input");
    a_pwm_follows_in: assert property ($changed(pwm_in) |=> $changed(pwm_active))
        else $error("pwm did not follow");
    a_hiz_zero_code: assert property (
        $stable(sensor_gain_resistor) |-> sensor_input_hiz == (sensor_gain_resistor == 7'h00))
        else $error("hiz flag wrong");
    a_boost_tick_gap: assert property (boost_sw_tick |=> s_boost_quiet ##[1:31] boost_sw_tick)
        else $error("boost tick spacing wrong");
    a_avg_tick_gap: assert property (sensor_avg_tick |-> gap_reg + 32'h1 >= AVG_BASE_CYC)
        else $error("averaging tick too early");
    a_avg_while_on: assert property (sensor_avg_tick |-> sensor_enable || $past(sensor_enable))
        else $error("averaging tick while off");
endmodule : lbc_checker

bind lbc_top lbc_checker #(.AVG_BASE_CYC(AVG_BASE_CYC)) u_lbc_checker (.mclk, .rst_n, .pwm_in,
    .lv_current_ctrl, .lv_pattern_en, .pattern_level, .bank_en, .pattern_run, .pattern_level_scaled,
    .lv_use_mapper_two, .lv_use_mapper_three, .pwm_active, .overvoltage_threshold, .boost_sw_tick,
    .sensor_gain_resistor, .sensor_input_hiz, .sensor_enable, .sensor_avg_tick);

// ---- lbc_host_model.sv ----
`timescale 1ns/1ns
module lbc_host_model #(
    parameter logic [6:0] DEV = lbc_pkg::DEV_ADDR_DEFAULT
) (
    input logic mclk,
    input logic sda_wire,
    output logic scl,
    output logic sda_low
);
    // released sda floats high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask : step
    // data moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        step(2);
        scl = 1'b1;
        step(2);
        r = sda_wire;
        step(2);
        scl = 1'b0;
        step(2);
    endtask : bit_io
    task automatic start();
        sda_low = 1'b0;
        step(2);
        scl = 1'b1;
        step(4);
        sda_low = 1'b1;
        step(4);
        scl = 1'b0;
        step(2);
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        step(2);
        scl = 1'b1;
        step(4);
        sda_low = 1'b0;
        step(4);
    endtask : stop
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic nack;
        for (int i = 7; i >= 0; i--) bit_io(d[i], nack);
        bit_io(1'b1, nack);
        ack = ~nack;
    endtask : put_byte
    task automatic write_reg(input logic wrong, input logic [7:0] ofs, input logic [7:0] d, output logic ok);
        logic [2:0] a;
        start();
        put_byte({DEV ^ {6'h00, wrong}, 1'b0}, a[0]);
        put_byte(ofs, a[1]);
        put_byte(d, a[2]);
        stop();
        ok = &a;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic [2:0] a;
        logic n;
        start();
        put_byte({DEV, 1'b0}, a[0]);
        put_byte(ofs, a[1]);
        start();
        put_byte({DEV, 1'b1}, a[2]);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, n);
        stop();
        if (a !== 3'h7) d = 'x;
    endtask : read_reg
endmodule : lbc_host_model

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
    import lbc_pkg::*;
    localparam int AVG = 8;
    localparam logic [7:0][7:0] OFS = REG_OFS;
    localparam int ZC [5] = '{3, 10, 5, 0, 7};
    logic mclk, rst_n, scl, host_sda_low, sda_wire, sda_out, sda_oe, pwm_in, pwm_active, boost_sw_tick;
    logic sensor_input_hiz, sensor_fast_startup, sensor_pwm_mode, sensor_enable, sensor_avg_tick;
    logic [3:0][1:0] lv_current_ctrl;
    logic [3:0] lv_pattern_en, pattern_run, lv_use_mapper_two, lv_use_mapper_three;
    logic [3:0][7:0] pattern_level, pattern_level_scaled;
    logic [2:0] active_zone;
    logic [5:0] bank_en;
    logic [1:0] overvoltage_threshold;
    logic [6:0] sensor_gain_resistor;
    int bad_count = 0, tests_run = 0, cyc = 0;
    assign sda_wire = ~(sda_oe | host_sda_low);
    lbc_top #(.AVG_BASE_CYC(AVG)) dut (.mclk, .rst_n, .scl_in(scl), .sda_in(sda_wire), .sda_out, .sda_oe,
        .pwm_in, .lv_current_ctrl, .lv_pattern_en, .pattern_level, .active_zone, .bank_en, .pattern_run,
        .pattern_level_scaled, .lv_use_mapper_two, .lv_use_mapper_three, .pwm_active, .overvoltage_threshold,
        .boost_sw_tick, .sensor_gain_resistor, .sensor_input_hiz, .sensor_fast_startup, .sensor_pwm_mode,
        .sensor_enable, .sensor_avg_tick);
    lbc_host_model host (.mclk, .sda_wire, .scl, .sda_low(host_sda_low));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic ok;
        host.write_reg(1'b0, ofs, d, ok);
        chk("write ack", 1, ok);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(ofs, d);
        chk($sformatf("reg %0h", ofs), exp, d);
    endtask : rd
    // first tick may use the old rate
    task automatic gap(input bit avg, output int n);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                host.step(1);
                n++;
            end while ((avg ? sensor_avg_tick : boost_sw_tick) !== 1'b1 && n < 2000);
        end
    endtask : gap
    task automatic t_reset_values();
        for (int i = 0; i < 8; i++) begin
            rd(OFS[i], REG_RST[i]);
        end
        chk("hiz", 1, sensor_input_hiz);
        chk("fast", 1, sensor_fast_startup);
        chk("pwm_active", 0, pwm_active);
        chk("sda_out", 0, sda_out);
    endtask : t_reset_values
    task automatic t_access();
        logic ok;
        for (int i = 0; i < 8; i++) begin
            wr(OFS[i], 8'hFF);
            rd(OFS[i], REG_MSK[i]);
            wr(OFS[i], 8'h00);
            rd(OFS[i], 8'h00);
        end
        wr(8'h2D, 8'h5A);
        rd(8'h2D, 8'h00);
        host.write_reg(1'b1, OFS[0], 8'h3F, ok);
        chk("foreign ack", 0, ok);
        rd(OFS[0], 8'h00);
    endtask : t_access
    task automatic t_banks_scaling();
        int e;
        wr(OFS[0], 8'h2A);
        chk("bank_en", 6'h2A, bank_en);
        wr(OFS[1], 8'h55);
        chk("pattern_run", 4'hF, pattern_run);
        pattern_level = {4{8'hA0}};
        wr(OFS[2], 8'h70);
        wr(OFS[3], 8'h5A);
        wr(OFS[4], 8'hF3);
        wr(OFS[1], 8'hAA);
        chk("pattern_run", 4'h0, pattern_run);
        for (int z = 0; z < 5; z++) begin
            active_zone = 3'(z);
            host.step(2);
            e = (160 * (ZC[z] + 1)) >> 4;
            for (int p = 0; p < 4; p++) chk("scaled", e, pattern_level_scaled[p]);
        end
        wr(OFS[1], 8'h08);
        chk("scaled p1", 8'hA0, pattern_level_scaled[0]);
        chk("scaled p2", 8'h50, pattern_level_scaled[1]);
    endtask : t_banks_scaling
    task automatic t_mapper();
        for (int c = 0; c < 4; c++) begin
            for (int e = 0; e < 2; e++) begin
                lv_current_ctrl = {4{2'(c)}};
                lv_pattern_en = e ? 4'h5 : 4'h0;
                host.step(2);
                chk("mapper two", c == 2 ? 4'(~lv_pattern_en) : 4'h0, lv_use_mapper_two);
                chk("mapper three", c == 3 ? 4'(~lv_pattern_en) : 4'h0, lv_use_mapper_three);
            end
        end
    endtask : t_mapper
    task automatic t_boost_pwm();
        int n;
        for (int k = 0; k < 4; k++) begin
            wr(OFS[5], 8'(k << 1));
            chk("overvoltage", k, overvoltage_threshold);
        end
        pwm_in = 1'b1;
        host.step(2);
        chk("pwm low pol", 0, pwm_active);
        wr(OFS[5], 8'h08);
        chk("pwm high pol", 1, pwm_active);
        gap(1'b0, n);
        chk("boost slow", 20, n);
        wr(OFS[5], 8'h09);
        gap(1'b0, n);
        chk("boost fast", 10, n);
    endtask : t_boost_pwm
    task automatic t_sensor();
        int n;
        wr(OFS[6], 8'h01);
        chk("hiz", 0, sensor_input_hiz);
        wr(OFS[6], 8'h7F);
        chk("gain", 7'h7F, sensor_gain_resistor);
        wr(OFS[7], 8'h06);
        chk("fast", 0, sensor_fast_startup);
        chk("pwm mode", 1, sensor_pwm_mode);
        chk("enable", 0, sensor_enable);
        for (int c = 0; c < 4; c += 3) begin
            wr(OFS[7], 8'(c << 3) | 8'h01);
            gap(1'b1, n);
            chk("avg period", AVG << c, n);
        end
        chk("fast", 1, sensor_fast_startup);
        wr(OFS[6], 8'h00);
        chk("hiz", 1, sensor_input_hiz);
    endtask : t_sensor
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        rst_n = 1'b0;
        pwm_in = 1'b0;
        lv_current_ctrl = '0;
        lv_pattern_en = '0;
        pattern_level = '0;
        active_zone = 3'h0;
        host.step(12);
        rst_n = 1'b1;
        host.step(1);
        t_reset_values();
        t_access();
        t_banks_scaling();
        t_mapper();
        t_boost_pwm();
        t_sensor();
        tally_and_finish();
    end
endmodule : tb
